// ===== verilog/apk_dev.sv
// apk_dev: packet generators, multiplexer and encoder
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
module apk_gen #(parameter int SYMS = 1)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic trig,
   input wire logic [apk_pkg::PKT_W-1:0] pkt,
   output logic [apk_pkg::SYM_W*SYMS-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic in_ready
);
   import apk_pkg::*;
   localparam int BEATS = PKT_SYMS / SYMS;
   localparam int BW = SYM_W * SYMS;
   localparam int CW = $clog2(BEATS + 1);
   logic [PKT_W-1:0] shreg;
   logic [CW-1:0] cnt;
   wire take = out_valid & out_ready;
   wire last = cnt == CW'(BEATS - 1);
   assign in_ready = ~out_valid | (take & last);
   assign out_data = shreg[BW-1:0];
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         out_valid <= 1'b0;
         cnt <= '0;
         shreg <= '0;
      end
      else if (trig && in_ready)
      begin
         out_valid <= 1'b1;
         cnt <= '0;
         shreg <= pkt;
      end
      else if (take)
      begin
         shreg <= shreg >> BW;
         cnt <= cnt + 1'b1;
         if (last)
            out_valid <= 1'b0;
      end
   end
endmodule

module apk_dev #(
   parameter int SYMS = 1,
   parameter int AUD_W = 32,
   parameter int ACR_PERIOD = apk_pkg::ACR_PERIOD_CYC,
   parameter logic [apk_pkg::VSI_CTL-1:0] VSI_DEFAULT = '0,
   parameter logic [apk_pkg::AI_CTL-1:0] AI_DEFAULT = '0,
   parameter logic [apk_pkg::FMT_W-1:0] FMT_3D = 4'h1,
   parameter logic [apk_pkg::FMT_W-1:0] FMT_MST = 4'h2
)
(
   input wire logic aclk,
   input wire logic aresetn,
   apk_aux_if.snk aux,
   input wire logic vsync,
   input wire logic vblank,
   input wire logic window_open,
   input wire logic [apk_pkg::GCP_W-1:0] gcp,
   input wire logic [apk_pkg::AVI_CTL:0] info_avi,
   input wire logic [apk_pkg::VSI_CTL:0] info_vsi,
   input wire logic [apk_pkg::AM_CTL:0] audio_metadata,
   input wire logic [apk_pkg::FMT_W-1:0] audio_format,
   input wire logic [apk_pkg::AI_CTL:0] sound_infoframe_bundle,
   input wire logic [apk_pkg::ACR_W-1:0] audio_n,
   input wire logic [apk_pkg::ACR_W-1:0] audio_cts,
   input wire logic [AUD_W-1:0] audio_data,
   input wire logic audio_valid,
   output logic audio_ready,
   output logic [apk_pkg::SYM_W*SYMS-1:0] tx_data,
   output logic tx_valid,
   output logic tx_first,
   output logic island_en
);
   import apk_pkg::*;
   localparam int BEATS = PKT_SYMS / SYMS;
   localparam int BW = SYM_W * SYMS;
   localparam int BCW = $clog2(BEATS + 1);
   localparam int ACW = $clog2(ACR_PERIOD + 1);
   localparam int GAP_CYC = VB_GAP_SYMS / SYMS;
   localparam int GW = $clog2(GAP_CYC + 1);
   localparam int RW = $clog2(VB_RUN + 1);

   function automatic logic [PKT_W-1:0] mk(input logic [TYPE_W-1:0] t,
                                           input logic [BODY_W-1:0] b);
      mk = {b, {(BODY_LSB - TYPE_W){1'b0}}, t};
   endfunction

   function automatic logic [SRC_W-1:0] rr_pick(input logic [NSRC-1:0] req,
                                                input logic [SRC_W-1:0] prev);
      logic [SRC_W-1:0] idx;
      logic found;
      rr_pick = prev;
      found = 1'b0;
      for (int i = 1; i <= NSRC; i++)
      begin
         idx = prev + SRC_W'(i);
         if (req[idx] && !found)
         begin
            rr_pick = idx;
            found = 1'b1;
         end
      end
   endfunction

   logic vs_d;
   logic [ACW-1:0] acr_cnt;
   logic [PKT_W-1:0] gpkt [NGEN];
   logic [NGEN-1:0] gtrig;
   logic [NGEN-1:0] gin_rdy;
   logic [BW-1:0] sdata [NSRC];
   logic [NSRC-1:0] sreq;
   logic [NSRC-1:0] srdy;
   logic [BCW-1:0] ubeat;
   logic udrop;
   apk_enc_e state;
   logic [BCW-1:0] bcnt;
   logic [SRC_W-1:0] gsel;
   logic gnull;
   logic [BCH_W-1:0] par;
   logic [BCH_W-1:0] next_par;
   logic [BW-1:0] enc_sym;
   logic [BW-1:0] chan_fmt;
   logic [RW-1:0] run;
   logic [GW-1:0] gap;

   // event detection
   wire vs_rise = vsync & ~vs_d;
   wire acr_tick = acr_cnt == ACW'(ACR_PERIOD - 1);
   wire avi_own = ~info_avi[AVI_CTL];
   wire vsi_own = ~info_vsi[VSI_CTL];
   wire am_own = ~audio_metadata[AM_CTL];
   wire ai_own = ~sound_infoframe_bundle[AI_CTL];
   wire am_fmt = (audio_format == FMT_3D) | (audio_format == FMT_MST);
   wire aud_take = audio_valid & audio_ready;
   wire [AVI_CTL-1:0] avi_f = info_avi[AVI_CTL-1:0];
   wire [VSI_CTL-1:0] vsi_f = info_vsi[VSI_CTL-1:0];
   wire [AI_CTL-1:0] ai_f = sound_infoframe_bundle[AI_CTL-1:0];

   // generators
   assign gtrig[SRC_GCP] = vs_rise;
   assign gtrig[SRC_AVI] = vs_rise & avi_own;
   assign gtrig[SRC_VSI] = vs_rise & vsi_own;
   assign gtrig[SRC_AM] = vs_rise & am_own & am_fmt;
   assign gtrig[SRC_AI] = vs_rise & ai_own;
   assign gtrig[SRC_ACR] = acr_tick;
   assign gtrig[SRC_AUD] = aud_take;
   assign gpkt[SRC_GCP] = mk(PT_GCP, BODY_W'(gcp));
   assign gpkt[SRC_AVI] = mk(PT_AVI, BODY_W'((|avi_f) ? avi_f : AVI_DEFAULT));
   assign gpkt[SRC_VSI] = mk(PT_VSI, BODY_W'((|vsi_f) ? vsi_f : VSI_DEFAULT));
   assign gpkt[SRC_AM] = mk(PT_AM, BODY_W'(audio_metadata[AM_CTL-1:0]));
   assign gpkt[SRC_AI] = mk(PT_AI, BODY_W'((|ai_f) ? ai_f : AI_DEFAULT));
   assign gpkt[SRC_ACR] = mk(PT_ACR, BODY_W'({audio_cts, audio_n}));
   assign gpkt[SRC_AUD] = mk(PT_SAMPLE, BODY_W'(audio_data));

   for (genvar g = 0; g < NGEN; g++)
   begin : gen_src
      apk_gen #(.SYMS(SYMS)) u_gen (
         .aclk(aclk),
         .aresetn(aresetn),
         .trig(gtrig[g]),
         .pkt(gpkt[g]),
         .out_data(sdata[g]),
         .out_valid(sreq[g]),
         .out_ready(srdy[g]),
         .in_ready(gin_rdy[g])
      );
   end

   // user port filtering
   wire ufirst = ubeat == '0;
   wire [TYPE_W-1:0] utype = aux.data[TYPE_W-1:0];
   wire type_drop = (utype == PT_GCP)
      | ((utype == PT_AVI) & avi_own)
      | ((utype == PT_VSI) & vsi_own)
      | ((utype == PT_AM) & am_own)
      | ((utype == PT_AI) & ai_own);
   wire drop_now = ufirst ? type_drop : udrop;
   wire uhs = aux.valid & aux.ready;
   assign sdata[SRC_USER] = aux.data;
   assign sreq[SRC_USER] = aux.valid & ~drop_now;
   assign aux.ready = drop_now | srdy[SRC_USER];

   // arbitration
   wire sending = state == ENC_SEND;
   wire last = sending && (bcnt == BCW'(BEATS - 1));
   wire gap_load = last & vblank & (run == RW'(VB_RUN - 1));
   wire start = island_en & ~gap_load & (~sending | last);
   wire any_req = |sreq;
   wire [SRC_W-1:0] pick = rr_pick(sreq, gsel);
   wire [BW-1:0] beat_in = gnull ? '0 : sdata[gsel];
   assign srdy = (sending && !gnull) ? (NSRC'(1) << gsel) : '0;

   // header parity into its slot
   always_comb
   begin
      next_par = (bcnt == '0) ? '0 : par;
      enc_sym = beat_in;
      for (int k = 0; k < BW; k++)
      begin
         if (int'(bcnt) * BW + k < HDR_W)
         begin
            if (beat_in[k] ^ next_par[0])
               next_par = (next_par >> 1) ^ BCH_POLY;
            else
               next_par = next_par >> 1;
         end
         else if (int'(bcnt) * BW + k < BODY_LSB)
            enc_sym[k] = next_par[int'(bcnt) * BW + k - HDR_W];
      end
   end

   // per-channel buses
   for (genvar s = 0; s < SYMS; s++)
   begin : gen_sym
      for (genvar c = 0; c < NCH; c++)
      begin : gen_ch
         assign chan_fmt[c*CH_W*SYMS + s*CH_W +: CH_W] = enc_sym[s*SYM_W + c*CH_W +: CH_W];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         vs_d <= 1'b0;
         acr_cnt <= '0;
         audio_ready <= 1'b0;
         ubeat <= '0;
         udrop <= 1'b0;
      end
      else
      begin
         vs_d <= vsync;
         acr_cnt <= acr_tick ? '0 : acr_cnt + 1'b1;
         audio_ready <= gin_rdy[SRC_AUD] & ~aud_take;
         if (uhs)
         begin
            ubeat <= (ubeat == BCW'(BEATS - 1)) ? '0 : ubeat + 1'b1;
            if (ufirst)
               udrop <= type_drop;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= ENC_IDLE;
         bcnt <= '0;
         gsel <= SRC_USER;
         gnull <= 1'b1;
         par <= '0;
         tx_data <= '0;
         tx_valid <= 1'b0;
         tx_first <= 1'b0;
      end
      else
      begin
         par <= next_par;
         tx_data <= chan_fmt;
         tx_valid <= sending;
         tx_first <= sending && (bcnt == '0);
         if (start)
         begin
            state <= ENC_SEND;
            bcnt <= '0;
            gnull <= ~any_req;
            if (any_req)
               gsel <= pick;
         end
         else if (last)
         begin
            state <= ENC_IDLE;
            bcnt <= '0;
         end
         else if (sending)
            bcnt <= bcnt + 1'b1;
      end
   end

   // vblank run limit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         run <= '0;
         gap <= '0;
         island_en <= 1'b0;
      end
      else
      begin
         if (!vblank || gap_load)
            run <= '0;
         else if (last)
            run <= run + 1'b1;
         if (gap_load)
            gap <= GW'(GAP_CYC);
         else if (gap != '0)
            gap <= gap - 1'b1;
         island_en <= window_open & ~gap_load & (gap <= GW'(1));
      end
   end
endmodule

// ===== verilog/apk_pkg.sv
// apk_pkg: shared constants of the auxiliary packet path
// Behaviour
// - round-robin feed of all sources into encoder
// - encoder splits symbols into TERC4 channel buses
// - encoder computes and inserts header BCH parity
// - feeder holds valid through whole packet
// - packet lasts 24, 12 or 6 clocks
// - generator input ready when idle or as last beat taken
// - generator valid holds until last beat taken
// - multiplexer round-robin with ready backpressure
// - user fields replace defaults when non-zero
// - control packet inserted at each vsync rise
// - user-port control packets always dropped
// - video info inserted, user copies dropped
// - video info control set: user copies pass
// - vendor packet: insert and filter, or pass
// - metadata: insert for 3D/multi-stream, or pass
// - sound info: insert and filter, or pass
// - clock regeneration packet every millisecond
// - user strips clock regeneration packets
// - device inserts samples; user strips them
// - window drops 32 symbols after 18 packets
package apk_pkg;
   localparam int SYM_W = 12;
   localparam int CH_W = 4;
   localparam int NCH = 3;
   localparam int PKT_SYMS = 24;
   localparam int PKT_W = SYM_W * PKT_SYMS;
   localparam int HDR_W = 24;
   localparam int BCH_W = 8;
   localparam int BODY_LSB = HDR_W + BCH_W;
   localparam int BODY_W = PKT_W - BODY_LSB;
   localparam int TYPE_W = 8;
   localparam logic [BCH_W-1:0] BCH_POLY = 8'h83;
   localparam int NSRC = 8;
   localparam int NGEN = 7;
   localparam int SRC_W = 3;
   localparam logic [SRC_W-1:0] SRC_GCP = 3'h0;
   localparam logic [SRC_W-1:0] SRC_AVI = 3'h1;
   localparam logic [SRC_W-1:0] SRC_VSI = 3'h2;
   localparam logic [SRC_W-1:0] SRC_AM = 3'h3;
   localparam logic [SRC_W-1:0] SRC_AI = 3'h4;
   localparam logic [SRC_W-1:0] SRC_ACR = 3'h5;
   localparam logic [SRC_W-1:0] SRC_AUD = 3'h6;
   localparam logic [SRC_W-1:0] SRC_USER = 3'h7;
   localparam logic [TYPE_W-1:0] PT_NULL = 8'h00;
   localparam logic [TYPE_W-1:0] PT_ACR = 8'h01;
   localparam logic [TYPE_W-1:0] PT_SAMPLE = 8'h02;
   localparam logic [TYPE_W-1:0] PT_GCP = 8'h03;
   localparam logic [TYPE_W-1:0] PT_AM = 8'h0d;
   localparam logic [TYPE_W-1:0] PT_VSI = 8'h81;
   localparam logic [TYPE_W-1:0] PT_AVI = 8'h82;
   localparam logic [TYPE_W-1:0] PT_AI = 8'h84;
   localparam int GCP_W = 6;
   localparam int AVI_CTL = 112;
   localparam int VSI_CTL = 61;
   localparam int AM_CTL = 165;
   localparam int AI_CTL = 48;
   localparam int FMT_W = 4;
   localparam int ACR_W = 20;
   localparam logic [AVI_CTL-1:0] AVI_DEFAULT = 112'h80067;
   localparam int VB_RUN = 18;
   localparam int VB_GAP_SYMS = 32;
   localparam int CLK_PERIOD_NS = 4;
   localparam int ACR_PERIOD_NS = 1000000;
   localparam int ACR_PERIOD_CYC = ACR_PERIOD_NS / CLK_PERIOD_NS;
   localparam int AXI_AW = 4;
   localparam int AXI_DW = 32;
   localparam logic [AXI_AW-1:0] REG_CTRL = 4'h0;
   localparam logic [AXI_AW-1:0] REG_HEAD = 4'h4;
   localparam logic [AXI_AW-1:0] REG_BODY = 4'h8;
   localparam logic [AXI_AW-1:0] REG_STAT = 4'hc;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CTRL_START = 0;
   localparam int CTRL_CLR = 1;
   localparam int CNT_W = 8;
   localparam int STAT_CNT_LSB = 8;
   typedef enum logic {ENC_IDLE = 1'b0, ENC_SEND = 1'b1} apk_enc_e;
   typedef enum logic {USR_IDLE = 1'b0, USR_SEND = 1'b1} apk_usr_e;
endpackage

// ===== verilog/apk_aux_if.sv
// apk_aux_if: auxiliary packet stream between user logic and the device
interface apk_aux_if #(parameter int SYMS = 1);
   import apk_pkg::*;
   logic [SYM_W*SYMS-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ===== verilog/apk_user.sv
// apk_user: register-driven user logic for the aux port
module apk_user #(parameter int SYMS = 1)
(
   input wire logic aclk,
   input wire logic aresetn,
   apk_aux_if.src aux,
   input wire logic [apk_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [apk_pkg::AXI_DW-1:0] s_axi_wdata,
   input wire logic [apk_pkg::AXI_DW/8-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [apk_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [apk_pkg::AXI_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import apk_pkg::*;
   localparam int BEATS = PKT_SYMS / SYMS;
   localparam int BW = SYM_W * SYMS;
   localparam int BCW = $clog2(BEATS + 1);
   localparam int NBW = BODY_W / AXI_DW;
   logic [AXI_AW-1:0] awa;
   logic [AXI_DW-1:0] wd;
   logic [AXI_DW/8-1:0] ws;
   logic [HDR_W-1:0] head;
   logic [AXI_DW-1:0] body;
   logic [PKT_W-1:0] shreg;
   logic [BCW-1:0] cnt;
   logic [CNT_W-1:0] sent;
   logic refused;
   apk_usr_e state;

   function automatic logic [AXI_DW-1:0] merge(input logic [AXI_DW-1:0] old,
      input logic [AXI_DW-1:0] d, input logic [AXI_DW/8-1:0] st);
      merge = old;
      for (int b = 0; b < AXI_DW / 8; b++)
         if (st[b])
            merge[b*8 +: 8] = d[b*8 +: 8];
   endfunction

   wire do_wr = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   wire wr_ctrl = do_wr & (awa == REG_CTRL);
   wire wr_head = do_wr & (awa == REG_HEAD);
   wire wr_body = do_wr & (awa == REG_BODY);
   wire wr_ok = wr_ctrl | wr_head | wr_body | (awa == REG_STAT);
   wire go = wr_ctrl & ws[0] & wd[CTRL_START] & (state == USR_IDLE);
   wire bad_type = (head[TYPE_W-1:0] == PT_ACR) | (head[TYPE_W-1:0] == PT_SAMPLE);
   wire clr = wr_ctrl & ws[0] & wd[CTRL_CLR];
   wire rd_hs = s_axi_arvalid & s_axi_arready;
   wire [AXI_DW-1:0] stat = {{(AXI_DW - STAT_CNT_LSB - CNT_W){1'b0}}, sent,
      {(STAT_CNT_LSB - 2){1'b0}}, refused, state == USR_SEND};
   wire [AXI_DW-1:0] rmux = (s_axi_araddr == REG_HEAD) ? AXI_DW'(head) :
      (s_axi_araddr == REG_BODY) ? body :
      (s_axi_araddr == REG_STAT) ? stat : '0;
   wire rd_ok = (s_axi_araddr == REG_CTRL) | (s_axi_araddr == REG_HEAD)
      | (s_axi_araddr == REG_BODY) | (s_axi_araddr == REG_STAT);
   wire last = cnt == BCW'(BEATS - 1);
   wire take = aux.valid & aux.ready;

   assign aux.valid = state == USR_SEND;
   assign aux.data = shreg[BW-1:0];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
         awa <= '0;
         wd <= '0;
         ws <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awa <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wd <= s_axi_wdata;
            ws <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (rd_hs)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rmux;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         head <= '0;
         body <= '0;
         state <= USR_IDLE;
         shreg <= '0;
         cnt <= '0;
         sent <= '0;
         refused <= 1'b0;
      end
      else
      begin
         if (wr_head)
            head <= HDR_W'(merge(AXI_DW'(head), wd, ws));
         if (wr_body)
            body <= merge(body, wd, ws);
         if (go && bad_type)
            refused <= 1'b1;
         else if (clr)
            refused <= 1'b0;
         if (go && !bad_type)
         begin
            state <= USR_SEND;
            cnt <= '0;
            shreg <= {{NBW{body}}, {BCH_W{1'b0}}, head};
         end
         else if (take)
         begin
            shreg <= shreg >> BW;
            cnt <= cnt + 1'b1;
            if (last)
            begin
               state <= USR_IDLE;
               sent <= sent + 1'b1;
            end
         end
      end
   end
endmodule

// ===== verification/apk_monitor.sv
// apk_monitor: stream and encoder assertions
module apk_monitor #(parameter int SYMS = 1)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [apk_pkg::SYM_W*SYMS-1:0] data,
   input wire logic valid,
   input wire logic ready,
   input wire logic tx_valid,
   input wire logic tx_first,
   input wire logic island_en
);
   import apk_pkg::*;
   localparam int BEATS = PKT_SYMS / SYMS;
   localparam int GAP = VB_GAP_SYMS / SYMS;
   logic [4:0] beat, txc;
   logic [7:0] gap;
   logic was_en;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         beat <= 5'h00;
         txc <= 5'h00;
         gap <= 8'h00;
         was_en <= 1'h0;
      end
      else
      begin
         was_en <= island_en;
         if (valid && ready)
            beat <= (beat == 5'(BEATS - 1)) ? 5'h00 : beat + 5'h01;
         if (tx_first)
            txc <= 5'(BEATS - 1);
         else if (txc != 5'h00)
            txc <= txc - 5'h01;
         if (island_en)
            gap <= 8'h00;
         else if (gap != 8'hff && (was_en || gap != 8'h00))
            gap <= gap + 8'h01;
      end
   end
   AST_HOLD_VALID: assert property (beat != 5'h00 |-> valid)
      else $error("valid dropped");
   AST_HOLD_DATA: assert property (valid && !ready |=> valid && $stable(data))
      else $error("data moved");
   AST_USER_TYPE: assert property (valid && beat == 5'h00 |->
      data[TYPE_W-1:0] != PT_ACR && data[TYPE_W-1:0] != PT_SAMPLE)
      else $error("user sent device type");
   AST_TX_CONT: assert property (txc != 5'h00 |-> tx_valid && !tx_first)
      else $error("tx short");
   AST_TX_START: assert property (tx_valid && txc == 5'h00 |-> tx_first)
      else $error("tx long");
   AST_TX_RUN: assert property (tx_first |=> (tx_valid && !tx_first) [*8])
      else $error("tx broken");
   AST_GAP_LEN: assert property ($rose(island_en) && gap != 8'h00 |-> gap >= 8'(GAP))
      else $error("window reopened early");
   AST_GAP_MIN: assert property ($fell(island_en) |-> !island_en [*8])
      else $error("gap short");
endmodule

// ===== verification/test_aux_packet_insert_path.sv
// test_aux_packet_insert_path: bench of both ends
module test_aux_packet_insert_path;
   timeunit 1ns;
   timeprecision 1ps;
   import apk_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0, vsync = 1'h0, vblank = 1'h0;
   logic window_open = 1'h1, audio_valid = 1'h0;
   logic [GCP_W-1:0] gcp = 6'h00;
   logic [AVI_CTL:0] info_avi = '0;
   logic [VSI_CTL:0] info_vsi = '0;
   logic [AM_CTL:0] audio_metadata = '0;
   logic [FMT_W-1:0] audio_format = 4'h0;
   logic [AI_CTL:0] sound_infoframe_bundle = '0;
   logic [ACR_W-1:0] audio_n = 20'h01800;
   logic [ACR_W-1:0] audio_cts = 20'h06978;
   logic [31:0] audio_data = 32'h0012abcd;
   logic audio_ready, tx_valid, tx_first, island_en;
   logic [SYM_W-1:0] tx_data;
   logic [AXI_AW-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [AXI_DW-1:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
   logic [PKT_W-1:0] cur, hit, avi0;
   logic [PKT_W-1:0] pkts[$];
   logic [7:0] ftype[5] = '{PT_GCP, PT_AVI, PT_VSI, PT_AM, PT_AI};
   int idx = 0, n = 0, fail_count = 0, check_count = 0;
   always #2 aclk = ~aclk;
   apk_aux_if #(.SYMS(1)) aux_c ();
   apk_user #(.SYMS(1)) apk_user_i (.aclk, .aresetn, .aux(aux_c), .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   apk_dev #(.SYMS(1), .ACR_PERIOD(200)) apk_dev_i (
      .aclk, .aresetn, .aux(aux_c), .vsync, .vblank, .window_open, .gcp, .info_avi,
      .info_vsi, .audio_metadata, .audio_format, .sound_infoframe_bundle, .audio_n,
      .audio_cts, .audio_data, .audio_valid, .audio_ready, .tx_data, .tx_valid,
      .tx_first, .island_en);
   apk_monitor #(.SYMS(1)) apk_monitor_i (.aclk, .aresetn, .data(aux_c.data),
      .valid(aux_c.valid), .ready(aux_c.ready), .tx_valid, .tx_first, .island_en);
   always @(posedge aclk)
   begin
      if (tx_valid)
      begin
         if (tx_first)
            idx = 0;
         cur[idx*SYM_W +: SYM_W] = tx_data;
         idx++;
         if (idx == PKT_SYMS)
            pkts.push_back(cur);
      end
   end
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] er);
      bit ao = 1'h0, wo = 1'h0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!(ao && wo))
      begin
         @(posedge aclk);
         ao |= s_axi_awready === 1'h1;
         wo |= s_axi_wready === 1'h1;
         s_axi_awvalid <= !ao;
         s_axi_wvalid <= !wo;
      end
      while (s_axi_bvalid !== 1'h1)
         @(posedge aclk);
      s_axi_bready <= 1'h0;
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask
   task automatic rd(logic [3:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
   endtask
   task automatic send(logic [7:0] t, logic [31:0] b);
      wr(REG_HEAD, {8'h00, 16'h0d02, t}, RESP_OKAY);
      wr(REG_BODY, b, RESP_OKAY);
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      rd(REG_STAT);
      for (int i = 0; i < 100 && rd_data[0] !== 1'h0; i++)
         rd(REG_STAT);
   endtask
   function automatic int count(logic [7:0] t, logic [31:0] m);
      int c = 0;
      foreach (pkts[i])
         if (pkts[i][7:0] === t && (m === '0 || pkts[i][PKT_W-32 +: 32] === m))
         begin
            c++;
            hit = pkts[i];
         end
      return c;
   endfunction
   task automatic settle();
      int n0 = count(PT_NULL, '0);
      for (int i = 0; i < 3000 && count(PT_NULL, '0) < n0 + 2; i++)
         @(posedge aclk);
   endtask
   function automatic logic [7:0] parity(logic [23:0] h);
      logic [7:0] p = 8'h00;
      for (int i = 0; i < HDR_W; i++)
         p = (p >> 1) ^ ((h[i] ^ p[0]) ? BCH_POLY : 8'h00);
      return p;
   endfunction
   initial
   begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      end_sim();
   end
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      rd(REG_CTRL);
      chk("ctrl", 32'h0, rd_data);
      rd(REG_STAT);
      chk("stat", 32'h0, rd_data);
      wr(REG_STAT, 32'hffffffff, RESP_OKAY);
      rd(REG_STAT);
      chk("stat ro", 32'h0, rd_data);
      wr(4'h6, 32'h0, RESP_SLVERR);
      rd(4'h2);
      chk("unmapped", 32'(RESP_SLVERR), 32'(rd_resp));
      for (int r = 0; r < 2; r++)
         foreach (ftype[k])
         begin
            info_avi[AVI_CTL] <= r[0];
            info_vsi[VSI_CTL] <= r[0];
            audio_metadata[AM_CTL] <= r[0];
            sound_infoframe_bundle[AI_CTL] <= r[0];
            pkts.delete();
            send(ftype[k], 32'h5eed0000 + k);
            settle();
            n = count(ftype[k], 32'h5eed0000 + k);
            chk("copy", 32'(r == 1 && k != 0), 32'(n));
            if (n == 1)
            begin
               chk("header", {8'h00, 16'h0d02, ftype[k]}, 32'(hit[23:0]));
               chk("parity", 32'(parity(hit[23:0])), 32'(hit[31:24]));
               chk("body", 32'h5eed0000 + k, hit[PKT_W-32 +: 32]);
            end
         end
      gcp <= 6'h25;
      for (int r = 0; r < 4; r++)
      begin
         audio_format <= (r == 0) ? 4'h1 : (r == 1) ? 4'h2 : 4'h3;
         info_avi <= {r == 3, 112'(r) * 112'h5a5a};
         info_vsi[VSI_CTL] <= r == 3;
         audio_metadata[AM_CTL] <= r == 3;
         sound_infoframe_bundle[AI_CTL] <= r == 3;
         pkts.delete();
         @(posedge aclk);
         vsync <= 1'h1;
         repeat (4) @(posedge aclk);
         vsync <= 1'h0;
         settle();
         chk("gcp", 32'h1, 32'(count(PT_GCP, '0)));
         chk("avi", 32'(r < 3), 32'(count(PT_AVI, '0)));
         if (r == 0)
            avi0 = hit;
         if (r == 1)
            chk("avi own", 32'h1, 32'(hit !== avi0));
         chk("vsi", 32'(r < 3), 32'(count(PT_VSI, '0)));
         chk("meta", 32'(r < 2), 32'(count(PT_AM, '0)));
         chk("sound", 32'(r < 3), 32'(count(PT_AI, '0)));
      end
      chk("null", 32'h1, 32'(count(PT_NULL, '0) > 0 && hit === '0));
      pkts.delete();
      audio_valid <= 1'h1;
      do @(posedge aclk); while (audio_ready !== 1'h1);
      audio_valid <= 1'h0;
      settle();
      chk("sample", 32'h1, 32'(count(PT_SAMPLE, '0)));
      pkts.delete();
      repeat (2000) @(posedge aclk);
      n = count(PT_ACR, '0);
      chk("acr", 32'h1, 32'(n >= 9 && n <= 11));
      for (int k = 0; k < 2; k++)
      begin
         pkts.delete();
         send((k != 0) ? PT_SAMPLE : PT_ACR, 32'hbad00000);
         settle();
         n = count((k != 0) ? PT_SAMPLE : PT_ACR, 32'hbad00000);
         chk("strip", 32'h0, 32'(n));
         rd(REG_STAT);
         chk("refused", 32'h1, 32'(rd_data[1]));
         wr(REG_CTRL, 32'h2, RESP_OKAY);
         rd(REG_STAT);
         chk("refused clr", 32'h0, 32'(rd_data[1]));
      end
      vblank <= 1'h1;
      for (int i = 0; i < 800 && island_en !== 1'h0; i++)
         @(posedge aclk);
      chk("drop", 32'h0, 32'(island_en));
      for (n = 0; island_en === 1'h0 && n < 200; n++)
         @(posedge aclk);
      chk("gap", 32'h1, 32'(n >= VB_GAP_SYMS));
      vblank <= 1'h0;
      end_sim();
   end
endmodule
